// ---- spae_peer.sv ----
// Behavioural serial peer that clocks frames through the port
`timescale 1ns/1ps
module spae_peer #(
	parameter int HALF_NS = 40
) (
	// Frame request from the bench
	input  wire logic        go_in,
	input  wire logic [4:0]  nbits_in,
	input  wire logic [15:0] word_in,
	input  wire logic        fsl_in,
	// Link towards the port
	input  wire logic        sdo_in,
	output logic             sck_out,
	output logic             fs_out,
	output logic             sdi_out,
	// Captured word and activity
	output logic [15:0]      word_out,
	output logic             busy_out
);
	initial begin
		sck_out = 1'b0;
		fs_out = 1'b0;
		sdi_out = 1'b0;
		word_out = 16'h0000;
		busy_out = 1'b0;
	end
	// Clock runs only inside a frame; data moves while sck is low
	always @(posedge go_in) begin
		busy_out = 1'b1;
		// Sync level of the slot; a low slot leaves the line still
		fs_out = fsl_in;
		#(HALF_NS);
		for (int i = 0; i < nbits_in; i++) begin
			sdi_out = word_in[15 - i];
			#(HALF_NS) sck_out = 1'b1;
			word_out = {word_out[14:0], sdo_in};
			#(HALF_NS) sck_out = 1'b0;
		end
		fs_out = 1'b0;
		// Released line shows the inverse, never a stale bit
		sdi_out = !sdi_out;
		#(HALF_NS) busy_out = 1'b0;
	end
endmodule

// ---- spae_pkg.sv ----
// Package with register map, field layout and shared types of the audio port
package spae_pkg;

	// Register byte offsets
	localparam logic [3:0] ctl_off       = 4'h0;
	localparam logic [3:0] ctl2_off      = 4'h4;
	localparam logic [3:0] stat_off      = 4'h8;
	localparam logic [3:0] mask_off      = 4'hC;
	localparam logic [3:0] txd_off       = 4'h0 + 4'h0;

	// Second control register field positions
	localparam int sgn_ext_bit   = 15;
	localparam int frm_en_bit    = 12;
	localparam int ovf_en_bit    = 11;
	localparam int unr_en_bit    = 10;
	localparam int ign_ovf_bit   = 9;
	localparam int ign_unr_bit   = 8;
	localparam int aud_en_bit    = 7;
	localparam int mono_bit      = 3;
	localparam int mode_lo_bit   = 0;

	// Writable field mask and reset value of the second control register
	localparam logic [31:0] ctl2_mask  = 32'h0000_9F8B;
	localparam logic [31:0] ctl2_reset = 32'h0000_0000;
	localparam logic [31:0] ctl2_lock  = 32'h0000_008B;

	// First control register: bit 0 is the module on bit
	localparam int on_bit = 0;

	// Status bit positions
	localparam int st_frm_bit = 0;
	localparam int st_ovf_bit = 1;
	localparam int st_unr_bit = 2;
	localparam int st_rx_bit  = 3;
	localparam logic [3:0] stat_reset = 4'h0;

	// Audio framing modes
	typedef enum logic [1:0] {
		spae_i2s   = 2'b00,
		spae_left  = 2'b01,
		spae_right = 2'b10,
		spae_pcm   = 2'b11
	} spae_mode_t;

	// Decoded second control register
	typedef struct packed {
		logic       sign_ext;
		logic       frm_en;
		logic       ovf_en;
		logic       unr_en;
		logic       ign_ovf;
		logic       ign_unr;
		logic       aud_en;
		logic       mono;
		spae_mode_t mode;
	} spae_cfg_t;

	// Error events from the serial engine
	typedef struct packed {
		logic frame_error_flag;
		logic overflow_flag;
		logic underrun_flag;
	} spae_err_t;

endpackage

// ---- spae_properties.sv ----
// Checker for the audio port register bus and status outputs
`timescale 1ns/1ps
module spae_properties (
	// Clock, reset and bus
	input wire logic        mclk_in,
	input wire logic        rst_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [3:0]  wb_adr_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic        wb_ack_out,
	input wire logic        wb_err_out,
	// Status outputs
	input wire logic        irq_out,
	input wire logic        halted_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// Write to the first control register, the only way out of a halt
	wire logic on_wr = wb_stb_in && wb_we_in && wb_adr_in == 4'h0;
	// Request taken with no answer pending
	sequence req_s;
		wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
	endsequence
	// One answer pulse, then a quiet cycle
	sequence ans_s;
		(wb_ack_out || wb_err_out) ##1 !(wb_ack_out || wb_err_out);
	endsequence
	a_answer_next: assert property (req_s |=> ans_s)
		else $error("request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held too long");
	a_err_pulse: assert property (wb_err_out |=> !wb_err_out)
		else $error("err held too long");
	a_answer_idle: assert property (!$past(wb_stb_in) |-> !wb_ack_out
		&& !wb_err_out) else $error("answer without request");
	a_answer_excl: assert property (!(wb_ack_out && wb_err_out))
		else $error("ack and err together");
	a_gaps_zero: assert property (
		wb_ack_out && !wb_we_in && wb_adr_in == 4'h4
		|-> (wb_dat_out & ~spae_pkg::ctl2_mask) == 32'h0)
		else $error("unused control bits read nonzero");
	a_reset_quiet: assert property (
		$fell(rst_in) |-> !irq_out && !halted_out)
		else $error("outputs active after reset");
	a_halt_exit: assert property (
		$fell(halted_out) |-> $past(on_wr) || $past(on_wr, 2)
		|| $past(on_wr, 3)) else $error("halt cleared by itself");
endmodule
bind spae_top spae_properties u_props (.mclk_in(mclk_in),
	.rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
	.wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.wb_err_out(wb_err_out), .irq_out(irq_out),
	.halted_out(halted_out));

// ---- spae_sync.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spae_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	// Asynchronous level in, synchronised level out
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta;  // First stage, read by second stage only

	// Two stages to settle metastability
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			meta  <= '0;
			q_out <= '0;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule

// ---- spae_tb_top.sv ----
// Self-checking bench for the audio port error control register
`timescale 1ns/1ps
module spae_tb_top;
	logic        mclk_in, rst_in, cyc, stb, we, werr;
	logic        ack, err, sck, fs, sdi, sdo, irq, halt, go, busy, fsl;
	logic [3:0]  adr, sel;
	logic [4:0]  nbits;
	logic [15:0] pw, pr;
	logic [31:0] wdat, rdat, rq;
	int          err_count, n_checks;
	spae_top uut (.mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .wb_err_out(err), .sck_in(sck),
		.frame_sync_in(fs), .sdi_in(sdi), .sdo_out(sdo),
		.irq_out(irq), .halted_out(halt));
	spae_peer u_peer (.go_in(go), .nbits_in(nbits), .word_in(pw),
		.fsl_in(fsl),
		.sdo_in(sdo), .sck_out(sck), .fs_out(fs), .sdi_out(sdi),
		.word_out(pr), .busy_out(busy));
	// 200 MHz system clock
	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic cycle: hold until ack or err, then drop for a cycle
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do @(posedge mclk_in);
		while (ack !== 1'b1 && err !== 1'b1 && ++n < 50);
		chk(n < 50, 1'b1);
		rq = rdat;
		werr = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		wb(1'b0, a, 32'h0, 4'hF);
		chk(rq & m, e);
	endtask
	// One frame from the peer; sync latency is a few clocks
	task automatic frame(input logic [4:0] n, input logic [15:0] w,
		input logic l = 1'b1);
		int k;
		k = 0;
		nbits <= n;
		pw <= w;
		fsl <= l;
		go <= 1'b1;
		@(posedge mclk_in);
		go <= 1'b0;
		do @(posedge mclk_in);
		while (busy !== 1'b0 && ++k < 400);
		chk(busy, 1'b0);
		repeat (4) @(posedge mclk_in);
	endtask
	// Port off, receive store freed, status cleared
	task automatic idle_port();
		wr(4'h0, 32'h0);
		wb(1'b0, 4'h0, 32'h0, 4'hF);
		wb(1'b0, 4'h8, 32'h0, 4'hF);
		chk(halt, 1'b0);
	endtask
	task automatic t_regs();
		rdc(4'h4, 32'h0);
		wr(4'h4, 32'hFFFF_FFFF);
		rdc(4'h4, 32'h0000_9F8B);
		wr(4'h0, 32'h0000_0001);
		wr(4'h4, 32'h0);
		rdc(4'h4, 32'h0000_008B);
		wr(4'h2, 32'h0);
		chk(werr, 1'b1);
		idle_port();
		wr(4'h4, 32'h0);
		rdc(4'h4, 32'h0);
	endtask
	task automatic t_rx(input logic [31:0] c2, input logic [31:0] e);
		wr(4'h4, c2);
		wr(4'h0, 32'hA5C3_0001);
		frame(5'd16, 16'h8002);
		chk(pr, 16'hA5C3);
		chk(halt, 1'b0);
		rdc(4'h0, e);
		idle_port();
	endtask
	task automatic t_ovf(input logic en, input logic ign);
		wr(4'h4, {20'h0, en, 1'b0, ign, 9'h0});
		wr(4'hC, 32'h2);
		wr(4'h0, 32'h1234_0001);
		frame(5'd16, 16'h1111);
		wr(4'h0, 32'h5678_0001);
		frame(5'd16, 16'h2222);
		chk(irq, en);
		chk(halt, !ign);
		rdc(4'h8, {30'h0, en, 1'b0}, 32'h2);
		chk(irq, 1'b0);
		if (ign) rdc(4'h0, 32'h0000_1111);
		idle_port();
	endtask
	task automatic t_unr(input logic en, input logic ign);
		wr(4'h4, {21'h0, en, 1'b0, ign, 8'h0});
		wr(4'hC, 32'h0);
		wr(4'h0, 32'hC3C3_0001);
		frame(5'd16, 16'h0);
		wb(1'b1, 4'h0, 32'hFFFF_0001, 4'h1);
		wb(1'b0, 4'h0, 32'h0, 4'hF);
		frame(5'd16, 16'h0);
		if (ign) chk(pr, 16'h0);
		chk(halt, !ign);
		chk(irq, 1'b0);
		rdc(4'h8, {29'h0, en, 2'h0}, 32'h4);
		idle_port();
	endtask
	task automatic t_frm(input logic en);
		wr(4'h4, {19'h0, en, 4'h3, 8'h0});
		wr(4'hC, 32'h1);
		wr(4'h0, 32'h0F0F_0001);
		frame(5'd8, 16'h0);
		frame(5'd16, 16'h0);
		chk(irq, en);
		rdc(4'h8, {31'h0, en}, 32'h1);
		idle_port();
	endtask
	// Mono audio: a left slot, then a right slot with sync held low.
	// I2S spends the first clock on the delay bit; PCM never starts
	// a slot on the falling sync, so the line keeps its last bit.
	task automatic t_aud(input logic [1:0] md, input logic [15:0] e1,
		input logic [15:0] e2);
		wr(4'h4, {30'h0000_00A2, md});
		wr(4'h0, 32'h6C35_0001);
		frame(5'd16, 16'h0);
		chk(pr, e1);
		frame(5'd16, 16'h0, 1'b0);
		chk(pr, e2);
		chk(halt, 1'b0);
		idle_port();
	endtask
	task automatic final_report();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		{rst_in, cyc, stb, we, go} = 5'b10000;
		{adr, sel, nbits, pw, wdat, fsl} = '0;
		err_count = 0;
		n_checks = 0;
		repeat (5) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		chk({irq, halt}, 2'b00);
		t_regs();
		t_rx(32'h0000_800B, 32'hFFFF_8003);
		t_rx(32'h0000_0002, 32'h0000_8003);
		t_ovf(1'b1, 1'b1);
		t_ovf(1'b1, 1'b0);
		t_ovf(1'b0, 1'b1);
		t_unr(1'b1, 1'b1);
		t_unr(1'b1, 1'b0);
		t_unr(1'b0, 1'b1);
		t_frm(1'b1);
		t_frm(1'b0);
		t_aud(2'b00, 16'h361A, 16'h361A);
		t_aud(2'b01, 16'h6C35, 16'h6C35);
		t_aud(2'b10, 16'h6C35, 16'h6C35);
		t_aud(2'b11, 16'h6C35, 16'hFFFF);
		final_report();
	end
	// Watchdog, nearly three times the expected run
	initial begin
		#100_000;
		err_count++;
		final_report();
	end
endmodule

// ---- spae_top.sv ----
// Audio serial port with error control, Wishbone registers and link engine
`timescale 1ns/1ps
module spae_top #(
	parameter int WORD_W = 16
) (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	// Wishbone slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [3:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	output logic             wb_err_out,
	// Serial link, peer drives the bit clock and frame sync
	input  wire logic        sck_in,
	input  wire logic        frame_sync_in,
	input  wire logic        sdi_in,
	output logic             sdo_out,
	// Interrupt
	output logic             irq_out,
	// Port halted after a critical error
	output logic             halted_out
);
	// Register contents
	logic [31:0]         ctl;          // Bit 0 turns the port on
	logic [31:0]         ctl2;         // Second control register
	logic [3:0]          stat;         // Sticky event bits
	logic [3:0]          mask;         // Interrupt mask
	logic [WORD_W-1:0]   transmit_buffer;
	logic                tx_full;      // Transmit buffer holds a word
	logic [WORD_W-1:0]   rx_hold;      // Single word receive store
	logic                rx_full;
	logic                halted;

	// Link engine state
	logic [WORD_W-1:0]   tx_shift;
	logic [WORD_W-1:0]   rx_shift;
	logic [WORD_W-1:0]   mono_word;    // Word repeated on second channel
	logic [5:0]          bit_cnt;
	logic                sck_d;
	logic                fs_d;

	// Synchronised pins
	logic sck_s;
	logic fs_s;
	logic sdi_s;

	spae_sync #(
		.W(3)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_in (rst_in),
		.d_in   ({sck_in, frame_sync_in, sdi_in}),
		.q_out  ({sck_s, fs_s, sdi_s})
	);

	// Decoded configuration
	spae_pkg::spae_cfg_t cfg;
	wire port_on = ctl[spae_pkg::on_bit];
	assign cfg.sign_ext = ctl2[spae_pkg::sgn_ext_bit];
	assign cfg.frm_en   = ctl2[spae_pkg::frm_en_bit];
	assign cfg.ovf_en   = ctl2[spae_pkg::ovf_en_bit];
	assign cfg.unr_en   = ctl2[spae_pkg::unr_en_bit];
	assign cfg.ign_ovf  = ctl2[spae_pkg::ign_ovf_bit];
	assign cfg.ign_unr  = ctl2[spae_pkg::ign_unr_bit];
	assign cfg.aud_en   = ctl2[spae_pkg::aud_en_bit];
	// Mono and mode only count in audio mode
	assign cfg.mono     = cfg.aud_en & ctl2[spae_pkg::mono_bit];
	assign cfg.mode     = cfg.aud_en ?
		spae_pkg::spae_mode_t'(ctl2[spae_pkg::mode_lo_bit +: 2]) :
		spae_pkg::spae_i2s;

	// Bus decode
	wire bus_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
	wire hit_ctl  = wb_adr_in == spae_pkg::ctl_off;
	wire hit_ctl2 = wb_adr_in == spae_pkg::ctl2_off;
	wire hit_stat = wb_adr_in == spae_pkg::stat_off;
	wire hit_mask = wb_adr_in == spae_pkg::mask_off;
	// Transmit word has no offset of its own; it rides on the ctl write
	wire mapped   = hit_ctl | hit_ctl2 | hit_stat | hit_mask;
	wire wr       = bus_req & wb_we_in & mapped;
	wire rd       = bus_req & ~wb_we_in & mapped;
	wire [31:0] bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
		{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

	// Writable bits of the second register; audio fields lock while on
	wire [31:0] ctl2_wmask = port_on ?
		(spae_pkg::ctl2_mask & ~spae_pkg::ctl2_lock) :
		spae_pkg::ctl2_mask;
	wire [31:0] ctl2_eff = ctl2_wmask & bmask;
	wire [31:0] next_ctl2 = (ctl2 & ~ctl2_eff) | (wb_dat_in & ctl2_eff);

	// Sign extension of received word on read; RX data lives at ctl offset
	wire [31:0] rx_word = cfg.sign_ext ?
		{{(32-WORD_W){rx_hold[WORD_W-1]}}, rx_hold} :
		{{(32-WORD_W){1'b0}}, rx_hold};

	// Read mux: upper half of ctl2 never stored, so it reads zero
	wire [31:0] rd_data =
		hit_ctl  ? {rx_word[31:1], port_on} :
		hit_ctl2 ? {16'h0000, ctl2[15:0]} :
		hit_stat ? {28'h000_0000, stat} :
		hit_mask ? {28'h000_0000, mask} : 32'h0000_0000;

	// Link edges
	wire sck_rise = sck_s & ~sck_d;
	wire sck_fall = ~sck_s & sck_d;
	wire fs_edge  = fs_s ^ fs_d;
	wire fs_rise  = fs_s & ~fs_d;
	// Audio framing starts on any sync change, PCM on the rising pulse
	wire frame_start = cfg.aud_en ?
		((cfg.mode == spae_pkg::spae_pcm) ? fs_rise : fs_edge) :
		fs_rise;
	// I2S delays data one bit after sync; the others start at once
	wire i2s_delay = cfg.aud_en & (cfg.mode == spae_pkg::spae_i2s);
	wire running   = port_on & ~halted;
	// Word completes on the rising edge that samples its last bit
	wire word_end  = running & sck_rise & ~frame_start
		& (bit_cnt == 6'(WORD_W - 1));
	wire [WORD_W-1:0] rx_next = {rx_shift[WORD_W-2:0], sdi_s};
	wire frm_err   = running & frame_start & (bit_cnt != 6'd0)
		& (bit_cnt != 6'(WORD_W));
	wire ovf_evt   = word_end & rx_full;
	// Slot that starts now, from the live sync level: low is right.
	// Using the slot just ended would repeat or drop the mono word.
	wire start_chan = cfg.aud_en & ~fs_s;
	wire need_tx   = running & frame_start & ~(cfg.mono & start_chan);
	wire unr_evt   = need_tx & ~tx_full;

	// Error events, gated per enable
	spae_pkg::spae_err_t err;
	assign err.frame_error_flag = frm_err & cfg.frm_en;
	assign err.overflow_flag    = ovf_evt & cfg.ovf_en;
	assign err.underrun_flag    = unr_evt & cfg.unr_en;

	// Critical errors halt the port unless ignored
	wire crit = (ovf_evt & ~cfg.ign_ovf) | (unr_evt & ~cfg.ign_unr);

	// Next transmit word: mono repeats, underrun sends zeros
	wire [WORD_W-1:0] tx_pick =
		(cfg.mono & start_chan) ? mono_word :
		tx_full ? transmit_buffer : '0;
	wire tx_write = wr & hit_ctl & wb_sel_in[1];

	// Bus answer, one cycle after request
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wb_ack_out <= 1'b0;
			wb_err_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= bus_req & mapped;
			wb_err_out <= bus_req & ~mapped;
			wb_dat_out <= rd_data;
		end
	end

	// Control registers
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ctl  <= 32'h0000_0000;
			ctl2 <= spae_pkg::ctl2_reset;
			mask <= spae_pkg::stat_reset;
		end else begin
			if (wr & hit_ctl & wb_sel_in[0])
				ctl[spae_pkg::on_bit] <= wb_dat_in[spae_pkg::on_bit];
			if (wr & hit_ctl2)
				ctl2 <= next_ctl2;
			if (wr & hit_mask & wb_sel_in[0])
				mask <= wb_dat_in[3:0];
		end
	end

	// Sticky status, read clears, a new event wins over the clear
	wire [3:0] evt = {word_end, err.underrun_flag, err.overflow_flag,
		err.frame_error_flag};
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			stat <= spae_pkg::stat_reset;
		end else begin
			stat <= ((rd & hit_stat) ? 4'h0 : stat) | evt;
		end
	end
	assign irq_out = |(stat & mask);

	// Transmit buffer loaded from the ctl word upper half on a ctl write with byte lane 1 enabled
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			transmit_buffer <= '0;
			tx_full         <= 1'b0;
		end else if (tx_write) begin
			transmit_buffer <= wb_dat_in[16 +: WORD_W];
			tx_full         <= 1'b1;
		end else if (need_tx) begin
			tx_full <= 1'b0;
		end
	end

	// Receive store; ignored overflow keeps the old word
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_hold <= '0;
			rx_full <= 1'b0;
		end else if (word_end & ~rx_full) begin
			rx_hold <= rx_next;
			rx_full <= 1'b1;
		end else if (rd & hit_ctl) begin
			rx_full <= 1'b0;
		end
	end

	// Halt on critical error, released by turning the port off
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			halted <= 1'b0;
		end else if (~port_on) begin
			halted <= 1'b0;
		end else if (crit) begin
			halted <= 1'b1;
		end
	end
	assign halted_out = halted;

	// Shift engine: load on frame start, shift out on fall, in on rise
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sck_d     <= 1'b0;
			fs_d      <= 1'b0;
			bit_cnt   <= 6'd0;
			tx_shift  <= '0;
			rx_shift  <= '0;
			mono_word <= '0;
			sdo_out   <= 1'b0;
		end else begin
			sck_d <= sck_s;
			fs_d  <= fs_s;
			if (!running) begin
				bit_cnt <= 6'd0;
				sdo_out <= 1'b0;
			end else if (frame_start) begin
				// Without the delay bit the first bit leaves at once,
				// so the shifter keeps only the bits still to go
				tx_shift  <= i2s_delay ? tx_pick :
					{tx_pick[WORD_W-2:0], 1'b0};
				mono_word <= tx_pick;
				bit_cnt   <= i2s_delay ? 6'd63 : 6'd0;
				if (!i2s_delay)
					sdo_out <= tx_pick[WORD_W-1];
			end else if (sck_rise && bit_cnt != 6'(WORD_W)) begin
				if (bit_cnt != 6'd63)
					rx_shift <= rx_next;
				bit_cnt <= bit_cnt + 6'd1;
			end else if (sck_fall && bit_cnt != 6'd63 &&
				bit_cnt != 6'(WORD_W)) begin
				sdo_out  <= tx_shift[WORD_W-1];
				tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
			end
		end
	end
endmodule
